/* src/usart_frame_baud_config.sv */
// Frame format, baud prescaler, auto-baud window and infrared event configuration block.
`include "usart_cfg_defs.svh"

module usart_frame_baud_config (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [1:0] RX_MODE,
    input wire logic DEBUG_HALT,
    input wire logic EVENT_RX,
    output logic IR_RX,
    output logic MULTIPROC_ENABLE,
    output usart_cfg_pkg::frame_cfg_t FRAME_CFG,
    output usart_cfg_pkg::rx_cfg_t RX_CFG,
    output logic [15:0] BAUD_DIVISOR,
    output logic [7:0] TX_PULSE_LENGTH,
    output logic SAMPLE_TICK,
    output logic BIT_TICK,
    output logic HALTED,
    input wire logic [7:0] SYNC_COUNT,
    input wire logic SYNC_VALID,
    output logic SYNC_OK,
    output logic SYNC_ERR,
    input wire logic [8:0] TX_CHAR,
    input wire logic TX_CHAR_VALID,
    output logic TX_CHAR_READY,
    output usart_cfg_pkg::tx_frame_t TX_FRAME,
    output logic TX_FRAME_VALID,
    input wire logic TX_FRAME_READY
);
    import usart_cfg_pkg::*;

    // ------------
    // Helper functions
    // ------------
    function automatic logic [3:0] size_bits(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h8;
        case (code)
            `SIZE_5BIT: n = 4'h5;
            `SIZE_6BIT: n = 4'h6;
            `SIZE_7BIT: n = 4'h7;
            `SIZE_9BIT_LOW, `SIZE_9BIT_HIGH: n = 4'h9;
            default: n = 4'h8;
        endcase
        return n;
    endfunction : size_bits

    function automatic logic [8:0] keep_bits(input logic [8:0] d, input logic [3:0] n);
        logic [8:0] m;
        m = 9'h1FF >> (4'h9 - n);
        return d & m;
    endfunction : keep_bits

    function automatic logic [7:0] flip8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction : flip8

    function automatic logic [7:0] window_tol(input logic [1:0] code);
        logic [7:0] t;
        t = `TOL_WINDOW_CODE_ZERO;
        case (code)
            2'h0: t = `TOL_WINDOW_CODE_ZERO;
            2'h1: t = `TOL_WINDOW_CODE_ONE;
            2'h2: t = `TOL_WINDOW_CODE_TWO;
            2'h3: t = `TOL_WINDOW_CODE_THREE;
            default: t = `TOL_WINDOW_CODE_ZERO;
        endcase
        return t;
    endfunction : window_tol

    // ------------
    // Registers
    // ------------
    logic [7:0] frame_ctrl_reg;
    logic [15:0] baud_reg;
    logic [7:0] autobaud_reg;
    logic run_reg;
    logic ir_event_reg;
    logic multiproc_reg;
    logic [7:0] tx_pulse_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    wire logic wr_frame = WR && (ADDR == `OFS_FRAME_CTRL);
    wire logic wr_baud_lo = WR && (ADDR == `OFS_BAUD_LOW);
    wire logic wr_baud_hi = WR && (ADDR == `OFS_BAUD_HIGH);
    wire logic wr_baud = wr_baud_lo || wr_baud_hi;
    wire logic wr_autobaud = WR && (ADDR == `OFS_AUTOBAUD);
    wire logic wr_debug = WR && (ADDR == `OFS_DEBUG);
    wire logic wr_ir = WR && (ADDR == `OFS_IR_EVENT);
    wire logic wr_mp = WR && (ADDR == `OFS_MULTIPROC);
    wire logic wr_pulse = WR && (ADDR == `OFS_TX_PULSE);

    // a write that selects SPI mode keeps only the SPI layout fields
    wire logic wr_is_spi = (WDATA[`MODE_HI:`MODE_LO] == MODE_SPI_HOST);
    // SPI layout holds mode, order and phase only
    wire logic [7:0] frame_ctrl_next = wr_is_spi ? (WDATA & `SPI_LAYOUT_MASK) : WDATA;

    // halt only while the debugger halts and run is clear
    wire logic halted = DEBUG_HALT && !run_reg;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            frame_ctrl_reg <= `FRAME_CTRL_RESET;
        end else if (wr_frame) begin
            frame_ctrl_reg <= frame_ctrl_next;
        end
    end

    // divisor split over low and high byte offsets
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            baud_reg <= 16'h0000;
        end else if (wr_baud_lo) begin
            baud_reg[7:0] <= WDATA;
        end else if (wr_baud_hi) begin
            baud_reg[15:8] <= WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            autobaud_reg <= `ZERO_BYTE;
            run_reg <= 1'b0;
            ir_event_reg <= 1'b0;
            multiproc_reg <= 1'b0;
            tx_pulse_reg <= `ZERO_BYTE;
        end else begin
            if (wr_autobaud) autobaud_reg <= WDATA & `AUTOBAUD_MASK;
            if (wr_debug) run_reg <= WDATA[0];
            if (wr_ir) ir_event_reg <= WDATA[0];
            if (wr_mp) multiproc_reg <= WDATA[0];
            if (wr_pulse) tx_pulse_reg <= WDATA;
        end
    end

    // ------------
    // Read port
    // ------------
    logic [1:0] count_reg;
    logic sync_ok_reg;
    logic sync_err_reg;
    logic sync_seen_ok_reg;
    logic sync_seen_err_reg;

    wire logic [7:0] status_word = {3'b000, sync_seen_err_reg, sync_seen_ok_reg, halted,
        count_reg};

    // Unmapped offsets read as zero so software never sees stale bus data.
    always_comb begin
        rdata_next = `ZERO_BYTE;
        case (ADDR)
            `OFS_MULTIPROC: rdata_next = {7'h00, multiproc_reg};
            `OFS_FRAME_CTRL: rdata_next = frame_ctrl_reg;
            `OFS_BAUD_LOW: rdata_next = baud_reg[7:0];
            `OFS_BAUD_HIGH: rdata_next = baud_reg[15:8];
            `OFS_AUTOBAUD: rdata_next = autobaud_reg;
            `OFS_DEBUG: rdata_next = {7'h00, run_reg};
            `OFS_IR_EVENT: rdata_next = {7'h00, ir_event_reg};
            `OFS_TX_PULSE: rdata_next = tx_pulse_reg;
            `OFS_STATUS: rdata_next = status_word;
            default: rdata_next = `ZERO_BYTE;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_reg <= `ZERO_BYTE;
        end else if (RD) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= `ZERO_BYTE;
        end
    end

    // ------------
    // Decoded configuration
    // ------------
    // mode field decode
    wire comm_mode_t mode = comm_mode_t'(frame_ctrl_reg[`MODE_HI:`MODE_LO]);
    wire logic spi_mode = (mode == MODE_SPI_HOST);
    wire logic [2:0] size_code = frame_ctrl_reg[`SIZE_HI:`SIZE_LO];
    frame_cfg_t cfg;

    always_comb begin
        cfg = '0;
        cfg.mode = mode;
        // upper parity bit enables, lower picks odd; reserved code acts as off
        cfg.parity_en = !spi_mode && frame_ctrl_reg[`PARITY_EN_BIT];
        cfg.parity_odd = !spi_mode && frame_ctrl_reg[`PARITY_ODD_BIT];
        // stop bit count for the transmitter
        cfg.two_stop = !spi_mode && frame_ctrl_reg[`STOP_BIT];
        cfg.char_bits = spi_mode ? 4'h8 : size_bits(size_code);
        cfg.nine_high_first = !spi_mode && (size_code == `SIZE_9BIT_HIGH);
        // SPI order bit, MSB first when clear
        cfg.msb_first = spi_mode && !frame_ctrl_reg[`ORDER_BIT];
        // SPI phase bit picks the sampling edge
        cfg.sample_trailing = spi_mode && frame_ctrl_reg[`PHASE_BIT];
    end

    // receiver view carries no stop bit count
    wire rx_cfg_t rx_cfg = '{char_bits: cfg.char_bits, parity_en: cfg.parity_en,
        parity_odd: cfg.parity_odd, nine_high_first: cfg.nine_high_first,
        msb_first: cfg.msb_first, sample_trailing: cfg.sample_trailing};

    // ------------
    // Baud prescaler
    // ------------
    logic [15:0] presc_reg;
    logic [4:0] sample_cnt_reg;
    logic sample_tick_reg;
    logic bit_tick_reg;

    wire logic presc_done = (presc_reg == 16'h0000);
    wire logic last_sample = (sample_cnt_reg == `SAMPLES_PER_BIT - 5'h01);

    // divisor writes restart the prescaler at once
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            presc_reg <= 16'h0000;
        end else if (wr_baud) begin
            presc_reg <= wr_baud_lo ? {baud_reg[15:8], WDATA} : {WDATA, baud_reg[7:0]};
        end else if (!halted) begin
            presc_reg <= presc_done ? baud_reg : presc_reg - 16'h0001;
        end
    end

    // sixteen sample ticks make one bit tick
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sample_cnt_reg <= 5'h00;
            sample_tick_reg <= 1'b0;
            bit_tick_reg <= 1'b0;
        end else begin
            sample_tick_reg <= !wr_baud && !halted && presc_done;
            bit_tick_reg <= !wr_baud && !halted && presc_done && last_sample;
            if (wr_baud) begin
                sample_cnt_reg <= 5'h00;
            end else if (!halted && presc_done) begin
                sample_cnt_reg <= last_sample ? 5'h00 : sample_cnt_reg + 5'h01;
            end
        end
    end

    // ------------
    // Auto-baud window check
    // ------------
    wire logic [7:0] tol = window_tol(autobaud_reg[`WINDOW_HI:`WINDOW_LO]);
    wire logic in_window = (SYNC_COUNT >= `SAMPLES_PER_PAIR - tol) &&
        (SYNC_COUNT <= `SAMPLES_PER_PAIR + tol);
    // window applies only in LIN-constrained auto-baud
    wire logic sync_check = SYNC_VALID && !halted && (RX_MODE == `RX_MODE_LIN_CONSTRAINED_AUTOBAUD);
    wire logic rd_status = RD && (ADDR == `OFS_STATUS);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync_ok_reg <= 1'b0;
            sync_err_reg <= 1'b0;
            sync_seen_ok_reg <= 1'b0;
            sync_seen_err_reg <= 1'b0;
        end else begin
            // accept counts inside thirty-two plus or minus tolerance
            sync_ok_reg <= sync_check && in_window;
            sync_err_reg <= sync_check && !in_window;
            // The new result wins over a status read that clears the old one.
            sync_seen_ok_reg <= (sync_check && in_window) || (sync_seen_ok_reg && !rd_status);
            sync_seen_err_reg <= (sync_check && !in_window) ||
                (sync_seen_err_reg && !rd_status);
        end
    end

    // ------------
    // Infrared event input
    // ------------
    logic ir_rx_reg;

    // event input feeds the receiver only when enabled in infrared mode
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ir_rx_reg <= 1'b1;
        end else if (!halted) begin
            ir_rx_reg <= (ir_event_reg && mode == MODE_INFRARED) ? EVENT_RX : 1'b1;
        end
    end

    // ------------
    // Transmit character buffer
    // ------------
    tx_frame_t buf_mem [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    tx_frame_t fmt;

    always_comb begin
        fmt = '0;
        fmt.nbits = cfg.char_bits;
        fmt.data = keep_bits(TX_CHAR, cfg.char_bits);
        // reverse the byte so bit 0 always leaves first
        if (cfg.msb_first) begin
            fmt.data = {1'b0, flip8(TX_CHAR[7:0])};
        end
        fmt.parity_en = cfg.parity_en;
        fmt.parity = (^fmt.data) ^ cfg.parity_odd;
        fmt.two_stop = cfg.two_stop;
    end

    // a halted block neither takes nor gives characters
    wire logic push = TX_CHAR_VALID && TX_CHAR_READY;
    wire logic pop = TX_FRAME_VALID && TX_FRAME_READY;
    assign TX_CHAR_READY = !halted && (count_reg != `BUF_DEPTH);
    assign TX_FRAME_VALID = !halted && (count_reg != 2'h0);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= !wr_ptr_reg;
            if (pop) rd_ptr_reg <= !rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else if (push) begin
            buf_mem[wr_ptr_reg] <= fmt;
        end
    end

    // ------------
    // Outputs
    // ------------
    assign RDATA = rdata_reg;
    assign IR_RX = ir_rx_reg;
    assign MULTIPROC_ENABLE = multiproc_reg;
    assign FRAME_CFG = cfg;
    assign RX_CFG = rx_cfg;
    assign BAUD_DIVISOR = baud_reg;
    assign TX_PULSE_LENGTH = tx_pulse_reg;
    assign SAMPLE_TICK = sample_tick_reg;
    assign BIT_TICK = bit_tick_reg;
    assign HALTED = halted;
    assign SYNC_OK = sync_ok_reg;
    assign SYNC_ERR = sync_err_reg;
    assign TX_FRAME = buf_mem[rd_ptr_reg];

endmodule : usart_frame_baud_config

/* common/usart_cfg_defs.svh */
// Register offsets, field positions, reset values and codes of the frame and baud configuration.
`ifndef USART_CFG_DEFS_SVH
`define USART_CFG_DEFS_SVH

// ------------
// Register offsets
// ------------
`define OFS_MULTIPROC 4'h6
`define OFS_FRAME_CTRL 4'h7
`define OFS_BAUD_LOW 4'h8
`define OFS_BAUD_HIGH 4'h9
`define OFS_AUTOBAUD 4'hA
`define OFS_DEBUG 4'hB
`define OFS_IR_EVENT 4'hC
`define OFS_TX_PULSE 4'hD
`define OFS_STATUS 4'hF

// ------------
// Reset values and masks
// ------------
`define FRAME_CTRL_RESET 8'h03
`define SPI_LAYOUT_MASK 8'hC6
`define AUTOBAUD_MASK 8'hC0
`define BIT0_MASK 8'h01
`define ZERO_BYTE 8'h00

// ------------
// Field positions
// ------------
`define MODE_HI 7
`define MODE_LO 6
`define PARITY_EN_BIT 5
`define PARITY_ODD_BIT 4
`define STOP_BIT 3
`define SIZE_HI 2
`define SIZE_LO 0
`define ORDER_BIT 2
`define PHASE_BIT 1
`define WINDOW_HI 7
`define WINDOW_LO 6

// ------------
// Codes and counts
// ------------
`define SIZE_5BIT 3'h0
`define SIZE_6BIT 3'h1
`define SIZE_7BIT 3'h2
`define SIZE_9BIT_LOW 3'h6
`define SIZE_9BIT_HIGH 3'h7
`define RX_MODE_LIN_CONSTRAINED_AUTOBAUD 2'h3
`define SAMPLES_PER_BIT 5'h10
`define SAMPLES_PER_PAIR 8'h20
`define TOL_WINDOW_CODE_ZERO 8'h06
`define TOL_WINDOW_CODE_ONE 8'h05
`define TOL_WINDOW_CODE_TWO 8'h07
`define TOL_WINDOW_CODE_THREE 8'h08
`define BUF_DEPTH 2'h2

`endif

/* common/usart_cfg_pkg.sv */
// Types shared by the frame and baud configuration block and its users.
package usart_cfg_pkg;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0,
        MODE_SYNC = 2'h1,
        MODE_INFRARED = 2'h2,
        MODE_SPI_HOST = 2'h3
    } comm_mode_t;

    typedef struct packed {
        comm_mode_t mode;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic [3:0] char_bits;
        logic nine_high_first;
        logic msb_first;
        logic sample_trailing;
    } frame_cfg_t;

    typedef struct packed {
        logic [3:0] char_bits;
        logic parity_en;
        logic parity_odd;
        logic nine_high_first;
        logic msb_first;
        logic sample_trailing;
    } rx_cfg_t;

    typedef struct packed {
        logic [8:0] data;
        logic [3:0] nbits;
        logic parity_en;
        logic parity;
        logic two_stop;
    } tx_frame_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : usart_cfg_pkg

/* bench/usart_frame_baud_config_asserts.sv */
// Concurrent checks on the ports of the frame and baud configuration block.
`include "usart_cfg_defs.svh"

module usart_frame_baud_config_asserts import usart_cfg_pkg::*; (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic [1:0] RX_MODE,
    input wire logic IR_RX,
    input wire logic MULTIPROC_ENABLE,
    input wire usart_cfg_pkg::frame_cfg_t FRAME_CFG,
    input wire usart_cfg_pkg::rx_cfg_t RX_CFG,
    input wire logic [15:0] BAUD_DIVISOR,
    input wire logic SAMPLE_TICK,
    input wire logic BIT_TICK,
    input wire logic HALTED,
    input wire logic [7:0] SYNC_COUNT,
    input wire logic SYNC_VALID,
    input wire logic SYNC_OK,
    input wire logic SYNC_ERR,
    input wire usart_cfg_pkg::tx_frame_t TX_FRAME,
    input wire logic TX_FRAME_VALID,
    input wire logic TX_FRAME_READY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // The sync bounds sit inside or outside every window so one check serves all codes.
    a_mproc_write: assert property (
        WR && ADDR == `OFS_MULTIPROC |=> MULTIPROC_ENABLE == $past(WDATA[0]))
        else $error("multiprocessor bit not stored");
    a_spi_fields: assert property (
        FRAME_CFG.mode == MODE_SPI_HOST |->
        FRAME_CFG.char_bits == 4'd8 && !FRAME_CFG.parity_en && !FRAME_CFG.two_stop)
        else $error("frame fields live in spi mode");
    a_rx_view: assert property (
        RX_CFG.char_bits == FRAME_CFG.char_bits && RX_CFG.parity_en == FRAME_CFG.parity_en
        && RX_CFG.msb_first == FRAME_CFG.msb_first)
        else $error("receiver view differs");
    a_baud_low: assert property (
        WR && ADDR == `OFS_BAUD_LOW |=> BAUD_DIVISOR[7:0] == $past(WDATA) && !SAMPLE_TICK)
        else $error("divisor low byte late");
    a_sync_pass: assert property (
        SYNC_VALID && RX_MODE == 2'h3 && !HALTED && SYNC_COUNT >= 8'd27
        && SYNC_COUNT <= 8'd37 |=> SYNC_OK && !SYNC_ERR)
        else $error("sync count not accepted");
    a_sync_fail: assert property (
        SYNC_VALID && RX_MODE == 2'h3 && !HALTED && (SYNC_COUNT <= 8'd23
        || SYNC_COUNT >= 8'd41) |=> SYNC_ERR && !SYNC_OK)
        else $error("sync count not rejected");
    a_sync_refuse: assert property (
        SYNC_VALID && RX_MODE != 2'h3 |=> !SYNC_OK && !SYNC_ERR)
        else $error("sync checked in wrong mode");
    a_bit_tick: assert property (
        BIT_TICK |-> SAMPLE_TICK)
        else $error("bit tick without sample tick");
    a_ir_idle: assert property (
        !HALTED && FRAME_CFG.mode != MODE_INFRARED |=> IR_RX)
        else $error("infrared input not idle");
    a_frame_hold: assert property (
        TX_FRAME_VALID && !TX_FRAME_READY && !HALTED |=>
        HALTED || (TX_FRAME_VALID && $stable(TX_FRAME)))
        else $error("stalled frame changed or dropped");
    a_rdata_idle: assert property (
        !$past(RD) |-> RDATA == 8'h00)
        else $error("read data without read");
endmodule : usart_frame_baud_config_asserts

bind usart_frame_baud_config usart_frame_baud_config_asserts chk (
    .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RX_MODE(RX_MODE), .IR_RX(IR_RX), .MULTIPROC_ENABLE(MULTIPROC_ENABLE),
    .FRAME_CFG(FRAME_CFG), .RX_CFG(RX_CFG), .BAUD_DIVISOR(BAUD_DIVISOR),
    .SAMPLE_TICK(SAMPLE_TICK), .BIT_TICK(BIT_TICK), .HALTED(HALTED),
    .SYNC_COUNT(SYNC_COUNT), .SYNC_VALID(SYNC_VALID), .SYNC_OK(SYNC_OK),
    .SYNC_ERR(SYNC_ERR), .TX_FRAME(TX_FRAME), .TX_FRAME_VALID(TX_FRAME_VALID),
    .TX_FRAME_READY(TX_FRAME_READY));

/* bench/frame_sink.sv */
// Behavioural receiver of transmit frames that can hold off the block.
module frame_sink import usart_cfg_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire usart_cfg_pkg::tx_frame_t frame,
    input wire logic frame_valid,
    output logic frame_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    tx_frame_t got [$];

    // Ready is registered, so a stall lands a cycle late, as a real shifter would.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_ready <= 1'b0;
        end else begin
            frame_ready <= !stall;
            if (frame_valid && frame_ready) begin
                got.push_back(frame);
            end
        end
    end
endmodule : frame_sink

/* bench/tb_usart_frame_baud_config.sv */
// Self-checking testbench of the frame and baud configuration block.
`include "usart_cfg_defs.svh"

module tb_usart_frame_baud_config import usart_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [1:0] rx_mode = 2'h0;
    logic dbg_halt = 1'b0;
    logic event_rx = 1'b1;
    logic ir_rx, mproc_en, s_tick, b_tick, halted, sync_ok, sync_err;
    frame_cfg_t fcfg;
    rx_cfg_t rcfg;
    logic [15:0] baud;
    logic [7:0] plen;
    logic [7:0] sync_count = 8'h00;
    logic sync_valid = 1'b0;
    logic [8:0] tx_char = 9'h000;
    logic tx_char_valid = 1'b0;
    logic tx_char_ready, tx_frame_valid, tx_frame_ready;
    tx_frame_t tx_frame;
    logic stall = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    usart_frame_baud_config dut (.CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .RX_MODE(rx_mode), .DEBUG_HALT(dbg_halt),
        .EVENT_RX(event_rx), .IR_RX(ir_rx), .MULTIPROC_ENABLE(mproc_en), .FRAME_CFG(fcfg),
        .RX_CFG(rcfg), .BAUD_DIVISOR(baud), .TX_PULSE_LENGTH(plen), .SAMPLE_TICK(s_tick),
        .BIT_TICK(b_tick), .HALTED(halted), .SYNC_COUNT(sync_count), .SYNC_VALID(sync_valid),
        .SYNC_OK(sync_ok), .SYNC_ERR(sync_err), .TX_CHAR(tx_char),
        .TX_CHAR_VALID(tx_char_valid), .TX_CHAR_READY(tx_char_ready), .TX_FRAME(tx_frame),
        .TX_FRAME_VALID(tx_frame_valid), .TX_FRAME_READY(tx_frame_ready));
    frame_sink sink (.clk(clk), .rst_n(rst_n), .stall(stall), .frame(tx_frame),
        .frame_valid(tx_frame_valid), .frame_ready(tx_frame_ready));

    // ------------
    // Bus and comparison tasks
    // ------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (s_tick !== 1'b1 && n < 200);
    endtask : wait_tick

    task automatic sync_pulse(input logic [7:0] c, input logic [1:0] exp);
        @(posedge clk);
        sync_count <= c;
        sync_valid <= 1'b1;
        @(posedge clk);
        sync_valid <= 1'b0;
        #1;
        check("sync result", {sync_ok, sync_err}, exp);
    endtask : sync_pulse

    task automatic push(input logic [8:0] c);
        @(posedge clk);
        tx_char <= c;
        tx_char_valid <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (tx_char_ready === 1'b1) break;
        end
        tx_char_valid <= 1'b0;
    endtask : push

    // ------------
    // Scenarios
    // ------------
    task automatic t_registers();
        logic [7:0] d;
        for (int i = 6; i < 15; i++) begin
            rd_reg(4'(i), d);
            check("reset value", d, (i == 7) ? 8'h03 : 8'h00);
        end
        check("reset size", fcfg.char_bits, 4'd8);
        wr_reg(`OFS_AUTOBAUD, 8'hFF);
        rd_reg(`OFS_AUTOBAUD, d);
        check("window field", d, 8'hC0);
        wr_reg(`OFS_TX_PULSE, 8'h5A);
        rd_reg(`OFS_TX_PULSE, d);
        check("pulse length", {d, plen}, 16'h5A5A);
        wr_reg(`OFS_MULTIPROC, 8'h01);
        #1;
        check("multiprocessor", mproc_en, 1'b1);
    endtask : t_registers

    task automatic t_frame_codes();
        logic [7:0] v;
        logic [3:0] bits [8] = '{4'd5, 4'd6, 4'd7, 4'd8, 4'd8, 4'd8, 4'd9, 4'd9};
        for (int i = 0; i < 8; i++) begin
            v = {2'(i % 3), i[1:0], i[0], i[2:0]};
            wr_reg(`OFS_FRAME_CTRL, v);
            #1;
            check("mode", fcfg.mode, v[7:6]);
            check("parity", {fcfg.parity_en, fcfg.parity_odd & v[5]}, {v[5], v[5] & v[4]});
            check("stop", fcfg.two_stop, v[3]);
            check("size", fcfg.char_bits, bits[i]);
            check("nine order", fcfg.nine_high_first, i == 7);
        end
        wr_reg(`OFS_FRAME_CTRL, 8'hFF);
        rd_reg(`OFS_FRAME_CTRL, v);
        check("spi layout", v, 8'hC6);
        check("spi order", {fcfg.mode, fcfg.msb_first, rcfg.msb_first}, 4'hC);
        check("spi phase", fcfg.sample_trailing, 1'b1);
        wr_reg(`OFS_FRAME_CTRL, 8'hC0);
        #1;
        check("spi msb", {fcfg.msb_first, fcfg.sample_trailing}, 2'b10);
    endtask : t_frame_codes

    task automatic t_baud();
        logic [7:0] d;
        int n;
        int k;
        wr_reg(`OFS_BAUD_HIGH, 8'h01);
        wr_reg(`OFS_BAUD_LOW, 8'h02);
        rd_reg(`OFS_BAUD_HIGH, d);
        check("divisor", {d, baud[7:0]}, 16'h0102);
        check("divisor value", baud, 16'h0102);
        wr_reg(`OFS_BAUD_HIGH, 8'h00);
        wait_tick(n);
        check("first tick", n, 16'd3);
        wait_tick(n);
        check("tick period", n, 16'd3);
        for (n = 0; n < 200 && b_tick !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        k = 0;
        do begin
            @(posedge clk);
            #1;
            if (s_tick === 1'b1) k++;
        end while (b_tick !== 1'b1 && k < 40);
        check("samples per bit", k, 16'd16);
    endtask : t_baud

    task automatic t_sync();
        logic [7:0] tol [4] = '{8'd6, 8'd5, 8'd7, 8'd8};
        logic [7:0] d;
        rx_mode <= 2'h3;
        for (int w = 0; w < 4; w++) begin
            wr_reg(`OFS_AUTOBAUD, {w[1:0], 6'h00});
            sync_pulse(8'd32 + tol[w], 2'b10);
            sync_pulse(8'd33 + tol[w], 2'b01);
            sync_pulse(8'd32 - tol[w], 2'b10);
            sync_pulse(8'd31 - tol[w], 2'b01);
        end
        rx_mode <= 2'h0;
        sync_pulse(8'd32, 2'b00);
        rd_reg(`OFS_STATUS, d);
        check("sticky flags", d, 8'h18);
        rd_reg(`OFS_STATUS, d);
        check("flags cleared", d, 8'h00);
    endtask : t_sync

    task automatic t_buffer();
        logic [8:0] ch [3] = '{9'h1A5, 9'h007, 9'h03C};
        tx_frame_t f;
        wr_reg(`OFS_FRAME_CTRL, 8'h2B);
        stall <= 1'b1;
        push(ch[0]);
        push(ch[1]);
        #1;
        check("buffer full", tx_char_ready, 1'b0);
        stall <= 1'b0;
        push(ch[2]);
        for (int n = 0; n < 100 && sink.got.size() < 3; n++) begin
            @(posedge clk);
        end
        check("frame count", sink.got.size(), 16'd3);
        for (int i = 0; i < 3; i++) begin
            f = sink.got[i];
            check("frame data", {f.nbits, 3'h0, f.data}, {4'd8, 4'h0, ch[i][7:0]});
            check("frame parity", {f.parity_en, f.parity}, {1'b1, ^ch[i][7:0]});
            check("frame stop", f.two_stop, 1'b1);
        end
    endtask : t_buffer

    task automatic t_debug_ir();
        int k;
        dbg_halt <= 1'b1;
        @(posedge clk);
        #1;
        check("halt", {halted, tx_char_ready}, 2'b10);
        k = 0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (s_tick !== 1'b0) k++;
        end
        check("halted ticks", k, 16'd0);
        wr_reg(`OFS_DEBUG, 8'h01);
        #1;
        check("run in halt", halted, 1'b0);
        dbg_halt <= 1'b0;
        wr_reg(`OFS_FRAME_CTRL, 8'h83);
        wr_reg(`OFS_IR_EVENT, 8'h01);
        event_rx <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("ir event on", ir_rx, 1'b0);
        wr_reg(`OFS_IR_EVENT, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        check("ir event off", ir_rx, 1'b1);
    endtask : t_debug_ir

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    always #4 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_registers();
        t_frame_codes();
        t_baud();
        t_sync();
        t_buffer();
        t_debug_ir();
        end_of_test();
    end
endmodule : tb_usart_frame_baud_config
